/* src/asr_pkg.sv */
// Package: register map, field layout, codes and types of the route block
`default_nettype none
package asr_pkg;
	// ==========================================================
	// Register offsets
	localparam logic [7:0] RX8_ROUTE_ADDR = 8'h2f;
	localparam logic [7:0] PRE_SRC_ADDR = 8'h32;
	localparam logic [7:0] SEC_SRC_ADDR = 8'h33;
	// ==========================================================
	// Reset values
	localparam logic [7:0] RX8_ROUTE_RST = 8'h07;
	localparam logic [7:0] PRE_SRC_RST = 8'h00;
	localparam logic [7:0] SEC_SRC_RST = 8'h00;
	localparam logic [1:0] RX8_DEST_RST = 2'h0;
	localparam logic [4:0] RX8_SLOT_RST = 5'h07;
	// ==========================================================
	// Field positions
	localparam int RX8_DEST_LSB = 5;
	localparam int RX8_SLOT_LSB = 0;
	localparam int PRE_SRC_LSB = 6;
	localparam int FIRST_DIV_LSB = 3;
	localparam int SEC_DIV_LSB = 4;
	// Writable bit masks; all other bits are reserved, read-only zero
	localparam logic [7:0] RX8_ROUTE_WMASK = 8'h7f;
	localparam logic [7:0] PRE_SRC_WMASK = 8'hf8;
	localparam logic [7:0] SEC_SRC_WMASK = 8'h70;
	// Slots per half frame in I2S and left-justified modes
	localparam logic [4:0] HALF_SLOTS = 5'h10;
	// ==========================================================
	// Codes
	typedef enum logic [1:0] {
		DEST_OFF = 2'h0,
		DEST_PLAYBACK8 = 2'h1,
		DEST_LOOPBACK4 = 2'h2,
		DEST_LINKED3 = 2'h3
	} asr_dest_type;
	typedef enum logic [1:0] {
		PRE_FIRST_BCLK = 2'h0,
		PRE_SECOND_BCLK = 2'h1,
		PRE_CTRL_CLK = 2'h2,
		PRE_OSC = 2'h3
	} asr_pre_type;
	typedef enum logic [2:0] {
		DIV_PLL = 3'h0,
		DIV_FIRST_BCLK = 3'h1,
		DIV_SECOND_BCLK = 3'h2,
		DIV_CTRL_CLK = 3'h3,
		DIV_OSC = 3'h4,
		DIV_DSP = 3'h5
	} asr_div_type;
	// Frame formats of the secondary port
	typedef enum logic [1:0] {
		FMT_TDM = 2'h0,
		FMT_I2S = 2'h1,
		FMT_LJ = 2'h2
	} asr_fmt_type;
	// ==========================================================
	// Carriers
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} asr_req_type;
	typedef struct packed {
		logic dis;
		logic playback;
		logic loopback;
		logic linked;
		logic right;
		logic [4:0] slot;
	} asr_route_type;
	// One-hot clock source selections; all zero means no clock
	typedef struct packed {
		logic [3:0] pre_sel;
		logic [5:0] first_sel;
		logic [5:0] second_sel;
	} asr_clksel_type;
endpackage
`default_nettype wire

/* src/asr_regbyte.sv */
// One configuration byte with write mask and reset value
`default_nettype none
module asr_regbyte #(
	parameter logic [7:0] RST_VAL = 8'h00,
	parameter logic [7:0] WMASK = 8'hff
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic we,
	input wire logic [7:0] wdata,
	output logic [7:0] q
);
	logic [7:0] q_reg;
	logic [7:0] q_next;
	// Reserved bits keep their reset value whatever is written
	assign q_next = we ? ((wdata & WMASK) | (RST_VAL & ~WMASK)) : q_reg;
	assign q = q_reg;
	// Storage
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			q_reg <= RST_VAL;
		end else begin
			q_reg <= q_next;
		end
	end
endmodule
`default_nettype wire

/* src/asr_top.sv */
// Secondary port channel 8 routing and clock source selection registers
// ==========================================================
`default_nettype none
module asr_top (
	input wire logic sys_clk,
	input wire logic rst,
	input wire asr_pkg::asr_req_type req,
	input wire asr_pkg::asr_fmt_type fmt,
	output logic [7:0] rdata,
	output logic rvalid,
	output logic ack_err,
	output asr_pkg::asr_route_type route,
	output asr_pkg::asr_clksel_type clksel
);
	import asr_pkg::*;

	// ==========================================================
	// Address decode
	wire hit_route = req.addr == RX8_ROUTE_ADDR;
	wire hit_pre = req.addr == PRE_SRC_ADDR;
	wire hit_sec = req.addr == SEC_SRC_ADDR;
	wire hit_any = hit_route | hit_pre | hit_sec;
	wire [7:0] route_q;
	wire [7:0] pre_q;
	wire [7:0] sec_q;

	// ==========================================================
	// Register bytes
	asr_regbyte #(.RST_VAL(RX8_ROUTE_RST), .WMASK(RX8_ROUTE_WMASK)) u_route (
		.sys_clk(sys_clk), .rst(rst), .we(req.wr & hit_route),
		.wdata(req.wdata), .q(route_q));
	asr_regbyte #(.RST_VAL(PRE_SRC_RST), .WMASK(PRE_SRC_WMASK)) u_pre (
		.sys_clk(sys_clk), .rst(rst), .we(req.wr & hit_pre),
		.wdata(req.wdata), .q(pre_q));
	asr_regbyte #(.RST_VAL(SEC_SRC_RST), .WMASK(SEC_SRC_WMASK)) u_sec (
		.sys_clk(sys_clk), .rst(rst), .we(req.wr & hit_sec),
		.wdata(req.wdata), .q(sec_q));

	// ==========================================================
	// Field extraction
	wire [1:0] dest_f = route_q[RX8_DEST_LSB +: 2];
	wire [4:0] slot_f = route_q[RX8_SLOT_LSB +: 5];
	wire [1:0] pre_f = pre_q[PRE_SRC_LSB +: 2];
	wire [2:0] first_f = pre_q[FIRST_DIV_LSB +: 3];
	wire [2:0] second_f = sec_q[SEC_DIV_LSB +: 3];

	// Divider source decode to one-hot; reserved codes give all zero
	function automatic logic [5:0] div_onehot(input logic [2:0] code,
			input logic [2:0] reserved);
		logic [5:0] v;
		v = 6'h00;
		if (code <= DIV_DSP && code != reserved) begin
			v[code] = 1'b1;
		end
		return v;
	endfunction

	// ==========================================================
	// Routing decode
	wire is_tdm = fmt == FMT_TDM;
	wire half_right = slot_f >= HALF_SLOTS;
	asr_route_type route_next;
	assign route_next.dis = dest_f == DEST_OFF;
	assign route_next.playback = dest_f == DEST_PLAYBACK8;
	assign route_next.loopback = dest_f == DEST_LOOPBACK4;
	assign route_next.linked = dest_f == DEST_LINKED3;
	assign route_next.right = !is_tdm && half_right;
	assign route_next.slot = (!is_tdm && half_right) ?
		slot_f - HALF_SLOTS : slot_f;

	// Clock selection decode
	asr_clksel_type clksel_next;
	assign clksel_next.pre_sel = 4'h1 << pre_f;
	assign clksel_next.first_sel = div_onehot(first_f, DIV_FIRST_BCLK);
	assign clksel_next.second_sel = div_onehot(second_f,
		DIV_SECOND_BCLK);

	// Read data mux; unmapped reads return zero with an error flag
	wire [7:0] rdata_next = hit_route ? route_q :
		hit_pre ? pre_q : hit_sec ? sec_q : 8'h00;

	// ==========================================================
	// Output registers
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			route <= '{dis: 1'b1, playback: 1'b0, loopback: 1'b0,
				linked: 1'b0, right: 1'b0, slot: RX8_SLOT_RST};
			clksel <= '{pre_sel: 4'h1, first_sel: 6'h01,
				second_sel: 6'h01};
			rdata <= 8'h00;
			rvalid <= 1'b0;
			ack_err <= 1'b0;
		end else begin
			route <= route_next;
			clksel <= clksel_next;
			rdata <= req.rd ? rdata_next : 8'h00;
			rvalid <= req.rd;
			ack_err <= (req.rd | req.wr) & !hit_any;
		end
	end

	// ==========================================================
	// Checks
	a_reset_route: assert property (@(posedge sys_clk)
		$fell(rst) |-> route.dis && route.slot == 5'h07)
		else $error("route not at reset default");
	a_dest_decode: assert property (@(posedge sys_clk) disable iff (rst)
		##1 route.linked == ($past(dest_f) == 2'h3))
		else $error("destination decode wrong");
	a_dest_onehot: assert property (@(posedge sys_clk) disable iff (rst)
		$onehot({route.dis, route.playback, route.loopback, route.linked}))
		else $error("destination not one-hot");
	a_right_slot: assert property (@(posedge sys_clk) disable iff (rst)
		(fmt != FMT_TDM && slot_f == 5'h1f) |=> route.right && route.slot == 5'h0f)
		else $error("right slot mapping wrong");
	a_tdm_slot: assert property (@(posedge sys_clk) disable iff (rst)
		(fmt == FMT_TDM) |=> !route.right && route.slot == $past(slot_f))
		else $error("tdm slot mapping wrong");
	a_pre_src: assert property (@(posedge sys_clk) disable iff (rst)
		(req.wr && hit_pre && req.wdata[7:6] == 2'h3) |=> ##1
		(clksel.pre_sel == 4'h8 || $past(req.wr && hit_pre)))
		else $error("prescaler source wrong");
	a_first_rsvd: assert property (@(posedge sys_clk) disable iff (rst)
		(first_f == 3'h1 || first_f > 3'h5) |=> clksel.first_sel == 6'h00)
		else $error("first reserved code gives clock");
	a_second_rsvd: assert property (@(posedge sys_clk) disable iff (rst)
		(second_f == 3'h2 || second_f > 3'h5) |=> clksel.second_sel == 6'h00)
		else $error("second reserved code gives clock");
	a_rsvd_bits: assert property (@(posedge sys_clk) disable iff (rst)
		pre_q[2:0] == 3'h0 && sec_q[7] == 1'b0 && sec_q[3:0] == 4'h0
		&& route_q[7] == 1'b0)
		else $error("reserved bit set");
	a_read_back: assert property (@(posedge sys_clk) disable iff (rst)
		(req.rd && hit_route) |=> rvalid && rdata == $past(route_q))
		else $error("read data wrong");
endmodule
`default_nettype wire

/* verification/asr_host_model.sv */
// Host on the second serial port: supplies the frame format
`default_nettype none
module asr_host_model (
	input wire logic sys_clk,
	input wire logic [1:0] fmt_req,
	output var asr_pkg::asr_fmt_type fmt
);
	timeunit 1ns;
	timeprecision 100ps;
	import asr_pkg::*;
	initial fmt = FMT_TDM;
	// The host switches format only at a clock edge
	always @(posedge sys_clk) begin
		fmt <= asr_fmt_type'(fmt_req);
	end
endmodule
`default_nettype wire

/* verification/testbench.sv */
// Bench: random register traffic compared with a reference model
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import asr_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	asr_req_type req = '0;
	logic [1:0] fmt_req = 2'h0;
	asr_fmt_type fmt;
	logic [7:0] rdata;
	logic rvalid;
	logic ack_err;
	asr_route_type route;
	asr_clksel_type clksel;
	int errors = 0;
	int checks = 0;
	int seed = 14902;
	logic [7:0] a;
	logic [7:0] d;
	// Reference register contents and writable masks
	logic [7:0] mdl [int] = '{RX8_ROUTE_ADDR: RX8_ROUTE_RST,
		PRE_SRC_ADDR: PRE_SRC_RST, SEC_SRC_ADDR: SEC_SRC_RST};
	logic [7:0] msk [int] = '{RX8_ROUTE_ADDR: RX8_ROUTE_WMASK,
		PRE_SRC_ADDR: PRE_SRC_WMASK, SEC_SRC_ADDR: SEC_SRC_WMASK};
	asr_host_model i_asr_host_model (.sys_clk(sys_clk),
		.fmt_req(fmt_req), .fmt(fmt));
	asr_top i_asr_top (.sys_clk(sys_clk), .rst(rst), .req(req),
		.fmt(fmt), .rdata(rdata), .rvalid(rvalid), .ack_err(ack_err),
		.route(route), .clksel(clksel));
	// ==========================================================
	// Clock, 25 ns period
	initial forever #12.5 sys_clk = ~sys_clk;
	// ==========================================================
	// Model helpers
	function automatic logic [5:0] sel6(logic [2:0] c, int rsv);
		return (c == rsv || c > 3'h5) ? 6'h00 : 6'h01 << c;
	endfunction
	function automatic logic [25:0] expect_out(int f);
		logic [7:0] r;
		logic [4:0] sl;
		logic rt;
		r = mdl[RX8_ROUTE_ADDR];
		sl = r[4:0];
		rt = f != 0 && sl >= 5'h10;
		return {r[6:5] == 2'h0, r[6:5] == 2'h1, r[6:5] == 2'h2,
			r[6:5] == 2'h3, rt, rt ? sl - 5'h10 : sl,
			4'h1 << mdl[PRE_SRC_ADDR][7:6],
			sel6(mdl[PRE_SRC_ADDR][5:3], 1), sel6(mdl[SEC_SRC_ADDR][6:4], 2)};
	endfunction
	task automatic tally(logic [25:0] got, logic [25:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_rd(logic [9:0] got, logic [9:0] exp);
		tally(26'(got), 26'(exp));
	endtask
	task automatic cmp_out(logic [25:0] got, logic [25:0] exp);
		tally(got, exp);
	endtask
	// One bus cycle; the answer is checked at the next falling edge
	task automatic access(logic w, logic [7:0] ad, logic [7:0] wd);
		logic un;
		logic [7:0] rd;
		un = !mdl.exists(int'(ad));
		rd = (w || un) ? 8'h00 : mdl[int'(ad)];
		req = '{wr: w, rd: !w, addr: ad, wdata: wd};
		@(negedge sys_clk);
		cmp_rd({rvalid, ack_err, rdata}, {!w, un, rd});
		if (w && !un)
			mdl[int'(ad)] = wd & msk[int'(ad)];
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		repeat (3) @(negedge sys_clk);
		rst = 1'b0;
		@(negedge sys_clk);
		foreach (mdl[k]) access(1'b0, 8'(k), 8'h00);
		req = '0;
		cmp_out({route, clksel}, expect_out(0));
		// Directed: right half slot 15, linked, oscillator prescaler
		fmt_req = 2'h1;
		access(1'b1, 8'h2f, 8'h7f);
		access(1'b1, 8'h32, 8'hf8);
		req = '0;
		repeat (2) @(negedge sys_clk);
		cmp_out({route, clksel}, expect_out(fmt_req));
		repeat (200) begin
			a = 8'h2f + 8'($unsigned($random(seed)) % 6);
			d = 8'($random(seed));
			// Software keeps reserved bits at their reset value of zero
			if (msk.exists(int'(a)))
				d = d & msk[int'(a)];
			fmt_req = 2'($random(seed));
			access(1'b1, a, d);
			access(1'b0, a, 8'h00);
			req = '0;
			repeat (2) @(negedge sys_clk);
			cmp_out({route, clksel}, expect_out(fmt_req));
		end
		// Mid-run reset brings every byte back to its default
		rst = 1'b1;
		repeat (3) @(negedge sys_clk);
		rst = 1'b0;
		mdl[RX8_ROUTE_ADDR] = RX8_ROUTE_RST;
		mdl[PRE_SRC_ADDR] = PRE_SRC_RST;
		mdl[SEC_SRC_ADDR] = SEC_SRC_RST;
		@(negedge sys_clk);
		cmp_out({route, clksel}, expect_out(fmt_req));
		foreach (mdl[k]) access(1'b0, 8'(k), 8'h00);
		req = '0;
		conclude();
	end
	// Watchdog well beyond the expected run time
	initial begin
		#100us;
		errors++;
		conclude();
	end
endmodule
`default_nettype wire
